// *** onoff_margin_ctrl.v ***
`timescale 1ns/1ps
`include "onoff_margin_map.vh"
// Contract
// - Run-and-margin byte at code 0x01, read/write
// - Bits 7:6 select immediate/soft off or enable
// - Bits 5:4 select nominal, low or high margin
// - Fault field 01 ignores OV/UV while margined
// - Fault field 10 acts on OV/UV while margined
// - Start-source byte at code 0x02, read/write
// - Bit4 zero: start whenever input power present
// - Bit4 one: wait for enabled start sources
// - Bit3 zero: ignore bus on/off field
// - Bit3 one: run only when bus says run
// - Bit2 selects whether control pin is used
// - Bit1 sets control pin active polarity
// - Bit0 zero: pin turn-off is soft sequenced
// - Bit0 one: pin turn-off is immediate
// - Write protect levels gate command writes
//
module onoff_margin_ctrl (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cmd_wr_i,
    input wire [7:0] cmd_code_i,
    input wire [7:0] cmd_wdata_i,
    input wire [7:0] cmd_raddr_i,
    output reg [7:0] cmd_rdata_o,
    output wire cmd_wr_refused_o,
    input wire control_pin_i,
    input wire power_present_i,
    output reg out_enable_o,
    output reg soft_off_o,
    output reg fast_off_o,
    output reg [1:0] margin_sel_o,
    output reg margined_o,
    output reg ovuv_ignore_o
);
    // =============================================================
    // Stored command bytes
    reg [7:0] run_and_margin_control;
    reg [7:0] start_source_config;
    reg [7:0] write_protect;
    wire write_ok;

    cmd_write_gate u_gate (
        .cmd_i(cmd_code_i),
        .protect_i(write_protect),
        .allow_o(write_ok)
    );

    // Refusal is a combinational handshake answer for this write
    assign cmd_wr_refused_o = cmd_wr_i && !write_ok;

    // A reserved 11 leaves the stored two-bit field alone
    function [1:0] keep_field;
        input [1:0] old_f;
        input [1:0] new_f;
        begin
            if (new_f == 2'h3) begin
                keep_field = old_f;
            end else begin
                keep_field = new_f;
            end
        end
    endfunction

    // Merge a written byte: 11 in the run or margin field keeps the old field
    function [7:0] merge_run;
        input [7:0] old_v;
        input [7:0] new_v;
        begin
            merge_run = new_v;
            merge_run[`RUN_HI:`RUN_LO] = keep_field(old_v[`RUN_HI:`RUN_LO],
                new_v[`RUN_HI:`RUN_LO]);
            merge_run[`MARGIN_HI:`MARGIN_LO] = keep_field(old_v[`MARGIN_HI:`MARGIN_LO],
                new_v[`MARGIN_HI:`MARGIN_LO]);
        end
    endfunction

    // =============================================================
    // Command register writes; reset stands for the power-up restore
    wire wr_taken = cmd_wr_i && write_ok;
    wire wr_run = wr_taken && (cmd_code_i == `CMD_RUN_MARGIN);
    wire wr_cfg = wr_taken && (cmd_code_i == `CMD_START_CFG);
    wire wr_prot = wr_taken && (cmd_code_i == `CMD_WRITE_PROTECT);

    // Run-and-margin byte; reserved run and margin fields keep their old value
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_and_margin_control <= `RST_RUN_MARGIN;
        end else if (wr_run) begin
            run_and_margin_control <= merge_run(run_and_margin_control, cmd_wdata_i);
        end
    end

    // Start-source byte; only the five defined bits are stored
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_source_config <= `RST_START_CFG;
        end else if (wr_cfg) begin
            start_source_config <= cmd_wdata_i & `CFG_USED_MASK;
        end
    end

    // Protect level; always writable so a lock can be lifted again
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_protect <= `RST_WRITE_PROTECT;
        end else if (wr_prot) begin
            write_protect <= cmd_wdata_i;
        end
    end

    // =============================================================
    // Readback, registered; reads ignore write protection
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_rdata_o <= 8'h00;
        end else begin
            case (cmd_raddr_i)
                `CMD_RUN_MARGIN: cmd_rdata_o <= run_and_margin_control;
                `CMD_START_CFG: cmd_rdata_o <= start_source_config;
                `CMD_WRITE_PROTECT: cmd_rdata_o <= write_protect;
                default: cmd_rdata_o <= 8'h00;
            endcase
        end
    end

    // =============================================================
    // Pin synchronisers; pin and power come from outside the clock
    reg pin_meta;
    reg pin_sync;
    reg pwr_meta;
    reg pwr_sync;

    // Control pin, two stages before any logic reads it
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= control_pin_i;
            pin_sync <= pin_meta;
        end
    end

    // Power flag; reset low so the output stays off until power is seen
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwr_meta <= 1'b0;
            pwr_sync <= 1'b0;
        end else begin
            pwr_meta <= power_present_i;
            pwr_sync <= pwr_meta;
        end
    end

    // =============================================================
    // Start-source evaluation
    wire [1:0] run_field = run_and_margin_control[`RUN_HI:`RUN_LO];
    wire [1:0] margin_field = run_and_margin_control[`MARGIN_HI:`MARGIN_LO];
    wire [1:0] fault_field = run_and_margin_control[`FAULT_HI:`FAULT_LO];
    wire pin_active = start_source_config[`CFG_PIN_POL] ? pin_sync : !pin_sync;
    wire pin_grant = !start_source_config[`CFG_PIN_EN] || pin_active;
    wire bus_grant = !start_source_config[`CFG_BUS_EN] || (run_field == `RUN_ENABLE);
    // Every enabled source must agree; with bit4 clear only power matters
    wire want_on = pwr_sync &&
        (!start_source_config[`CFG_POWERUP] || (pin_grant && bus_grant));
    // Which source is the one pulling the output down
    wire pin_stops = start_source_config[`CFG_POWERUP] && !pin_grant;
    wire bus_stops = start_source_config[`CFG_POWERUP] && !bus_grant;
    wire bus_fast = bus_stops && (run_field == `RUN_IMM_OFF);
    wire pin_fast = pin_stops && start_source_config[`CFG_PIN_FAST];
    wire next_fast = !want_on && (!pwr_sync || bus_fast || pin_fast);
    wire is_margined = (margin_field == `MARGIN_LOW) || (margin_field == `MARGIN_HIGH);

    // =============================================================
    // Next output values, settled before the register edge
    reg next_on;
    reg next_soft;
    reg [1:0] next_margin_sel;
    reg next_margined;
    reg next_ovuv_ignore;
    // Margin view only while on; off shows nominal
    always @* begin
        next_on = 1'b0;
        next_soft = 1'b0;
        next_margin_sel = `MARGIN_NOM;
        next_margined = 1'b0;
        next_ovuv_ignore = 1'b0;
        if (want_on) begin
            next_on = 1'b1;
            next_margin_sel = margin_field;
            next_margined = is_margined;
            // Fault masking only applies while margined
            next_ovuv_ignore = is_margined && (fault_field == `FAULT_IGNORE);
        end else begin
            // Fast wins when any stopping source demands it, the safer choice
            next_soft = !next_fast;
        end
    end

    // =============================================================
    // Output state, registered so the power stage sees clean levels
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_enable_o <= 1'b0;
            soft_off_o <= 1'b0;
            fast_off_o <= 1'b0;
            margin_sel_o <= 2'h0;
            margined_o <= 1'b0;
            ovuv_ignore_o <= 1'b0;
        end else begin
            out_enable_o <= next_on;
            fast_off_o <= next_fast;
            soft_off_o <= next_soft;
            margin_sel_o <= next_margin_sel;
            margined_o <= next_margined;
            ovuv_ignore_o <= next_ovuv_ignore;
        end
    end
endmodule

// *** onoff_margin_map.vh ***
`ifndef ONOFF_MARGIN_MAP_VH
`define ONOFF_MARGIN_MAP_VH
// =============================================================
// Command codes
`define CMD_RUN_MARGIN 8'h01
`define CMD_START_CFG 8'h02
`define CMD_WRITE_PROTECT 8'h10
// =============================================================
// Run-and-margin control fields
`define RUN_HI 7
`define RUN_LO 6
`define MARGIN_HI 5
`define MARGIN_LO 4
`define FAULT_HI 3
`define FAULT_LO 2
`define RUN_IMM_OFF 2'h0
`define RUN_SOFT_OFF 2'h1
`define RUN_ENABLE 2'h2
`define MARGIN_NOM 2'h0
`define MARGIN_LOW 2'h1
`define MARGIN_HIGH 2'h2
`define FAULT_IGNORE 2'h1
`define FAULT_ACT 2'h2
// =============================================================
// Start-source configuration fields
`define CFG_POWERUP 4
`define CFG_BUS_EN 3
`define CFG_PIN_EN 2
`define CFG_PIN_POL 1
`define CFG_PIN_FAST 0
`define CFG_USED_MASK 8'h1F
// =============================================================
// Write protect levels
`define WP_ALL 8'h80
`define WP_RUN_OK 8'h40
`define WP_CFG_OK 8'h20
// =============================================================
// Reset values (power-up restore defaults)
`define RST_RUN_MARGIN 8'h88
`define RST_START_CFG 8'h1E
`define RST_WRITE_PROTECT 8'h00
`endif

// *** cmd_write_gate.v ***
`timescale 1ns/1ps
`include "onoff_margin_map.vh"
// Decides whether a command write may land under write protection
module cmd_write_gate (
    input wire [7:0] cmd_i,
    input wire [7:0] protect_i,
    output wire allow_o
);
    // =============================================================
    // Protection decode
    wire is_wp = (cmd_i == `CMD_WRITE_PROTECT);
    wire is_run = (cmd_i == `CMD_RUN_MARGIN);
    wire is_cfg = (cmd_i == `CMD_START_CFG);
    // Protect command itself is always writable, else the lock is permanent
    assign allow_o = is_wp ||
        (protect_i == `WP_ALL ? 1'b0 :
         protect_i == `WP_RUN_OK ? is_run :
         protect_i == `WP_CFG_OK ? (is_run || is_cfg) : 1'b1);
endmodule

// *** onoff_margin_chk.sv ***
`timescale 1ns/1ps
// ====================
// Port relations of the on/off and margin block
module onoff_margin_chk (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cmd_wr_i,
    input wire [7:0] cmd_code_i,
    input wire [7:0] cmd_raddr_i,
    input wire [7:0] cmd_rdata_o,
    input wire cmd_wr_refused_o,
    input wire power_present_i,
    input wire out_enable_o,
    input wire soft_off_o,
    input wire fast_off_o,
    input wire [1:0] margin_sel_o,
    input wire margined_o,
    input wire ovuv_ignore_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Three low samples cover the two sync stages plus the output register
    sequence s_no_power; !power_present_i [*3]; endsequence
    property p_power; s_no_power |=> !out_enable_o; endproperty
    a_power: assert property (p_power) else $error("output on without power");
    property p_ign; ovuv_ignore_o |-> margined_o && out_enable_o; endproperty
    a_ign: assert property (p_ign) else $error("faults ignored while not margined");
    property p_mrg; margined_o |-> out_enable_o && margin_sel_o != 2'h0; endproperty
    a_mrg: assert property (p_mrg) else $error("margined flag without margin level");
    property p_act; out_enable_o |-> !soft_off_o && !fast_off_o; endproperty
    a_act: assert property (p_act) else $error("on and off together");
    property p_off; $fell(out_enable_o) |-> soft_off_o || fast_off_o; endproperty
    a_off: assert property (p_off) else $error("turn off without an off style");
    property p_sel; margin_sel_o != 2'h3; endproperty
    a_sel: assert property (p_sel) else $error("reserved margin level shown");
    property p_ref; cmd_wr_refused_o |-> cmd_wr_i && cmd_code_i != 8'h10; endproperty
    a_ref: assert property (p_ref) else $error("bad refusal");
    property p_cfg; cmd_raddr_i == 8'h02 |=> cmd_rdata_o[7:5] == 3'h0; endproperty
    a_cfg: assert property (p_cfg) else $error("unused config bits read back set");
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
// ====================
// Host side of the command port
module host_model (
    input wire clk_i,
    input wire [7:0] rdata_i,
    input wire refused_i,
    output reg wr_o = 1'b0,
    output reg [7:0] code_o = 8'h00,
    output reg [7:0] wdata_o = 8'h00,
    output reg [7:0] raddr_o = 8'h00
);
    // One-cycle strobe; refusal is taken at the edge that takes the write
    task wr(input [7:0] c, input [7:0] d, output r);
        @(posedge clk_i);
        wr_o <= 1'b1;
        code_o <= c;
        wdata_o <= d;
        @(posedge clk_i);
        r = refused_i;
        wr_o <= 1'b0;
    endtask
    // Read data is registered, so take it one edge later
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk_i);
        raddr_o <= a;
        @(posedge clk_i);
        #1 d = rdata_i;
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
// ====================
// Bench for the on/off and margin block
module tb;
    reg core_clk_i = 1'b0;
    reg rst_n_i = 1'b0;
    reg control_pin_i = 1'b1;
    reg power_present_i = 1'b1;
    wire cmd_wr_i, cmd_wr_refused_o, out_enable_o, soft_off_o, fast_off_o, margined_o, ovuv_ignore_o;
    wire [7:0] cmd_code_i, cmd_wdata_i, cmd_raddr_i, cmd_rdata_o;
    wire [1:0] margin_sel_o;
    wire [7:0] st = {1'b0, out_enable_o, soft_off_o, fast_off_o, margined_o, ovuv_ignore_o, margin_sel_o};
    integer bad_count = 0;
    integer n_checks = 0;
    reg r;
    reg [7:0] d;
    initial forever #20 core_clk_i = ~core_clk_i;
    onoff_margin_ctrl uut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .cmd_wr_i(cmd_wr_i),
        .cmd_code_i(cmd_code_i),
        .cmd_wdata_i(cmd_wdata_i),
        .cmd_raddr_i(cmd_raddr_i),
        .cmd_rdata_o(cmd_rdata_o),
        .cmd_wr_refused_o(cmd_wr_refused_o),
        .control_pin_i(control_pin_i),
        .power_present_i(power_present_i),
        .out_enable_o(out_enable_o),
        .soft_off_o(soft_off_o),
        .fast_off_o(fast_off_o),
        .margin_sel_o(margin_sel_o),
        .margined_o(margined_o),
        .ovuv_ignore_o(ovuv_ignore_o)
    );
    host_model host (.clk_i(core_clk_i), .rdata_i(cmd_rdata_o), .refused_i(cmd_wr_refused_o), .wr_o(cmd_wr_i),
        .code_o(cmd_code_i), .wdata_o(cmd_wdata_i), .raddr_o(cmd_raddr_i));
    // ====================
    // Shared compare and access tasks
    task chk(input [39:0] n, input [7:0] e, input [7:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("unexpected %0s expected %h seen %h", n, e, g);
        end
    endtask
    task w(input [7:0] c, input [7:0] v, input er);
        host.wr(c, v, r);
        chk("ref", {7'h00, er}, {7'h00, r});
    endtask
    task rc(input [7:0] a, input [7:0] e);
        host.rd(a, d);
        chk("rdata", e, d);
    endtask
    // Pin settles after three edges, longer than any write takes
    task so(input p, input [7:0] e);
        @(posedge core_clk_i);
        control_pin_i <= p;
        repeat (3) @(posedge core_clk_i);
        #1 chk("state", e, st);
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // ====================
    // Test sequence
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rc(8'h01, 8'h88);
        rc(8'h02, 8'h1E);
        so(1'b1, 8'h40);
        so(1'b0, 8'h20);
        w(8'h02, 8'h1F, 1'b0);
        so(1'b0, 8'h10);
        w(8'h02, 8'h1C, 1'b0);
        so(1'b0, 8'h40);
        so(1'b1, 8'h20);
        w(8'h02, 8'h18, 1'b0);
        so(1'b1, 8'h40);
        w(8'h01, 8'h48, 1'b0);
        so(1'b0, 8'h20);
        w(8'h01, 8'h08, 1'b0);
        so(1'b0, 8'h10);
        w(8'h01, 8'h94, 1'b0);
        so(1'b0, 8'h4D);
        w(8'h01, 8'hA8, 1'b0);
        so(1'b0, 8'h4A);
        w(8'h01, 8'hFC, 1'b0);
        so(1'b0, 8'h4A);
        w(8'h02, 8'h10, 1'b0);
        w(8'h01, 8'h48, 1'b0);
        so(1'b0, 8'h40);
        w(8'h02, 8'h00, 1'b0);
        so(1'b0, 8'h40);
        @(posedge core_clk_i);
        power_present_i <= 1'b0;
        so(1'b0, 8'h10);
        @(posedge core_clk_i);
        power_present_i <= 1'b1;
        w(8'h10, 8'h80, 1'b0);
        w(8'h01, 8'h88, 1'b1);
        w(8'h02, 8'h1E, 1'b1);
        rc(8'h01, 8'h48);
        w(8'h10, 8'h40, 1'b0);
        w(8'h01, 8'h88, 1'b0);
        w(8'h02, 8'h1E, 1'b1);
        w(8'h10, 8'h20, 1'b0);
        w(8'h02, 8'hFF, 1'b0);
        rc(8'h02, 8'h1F);
        rc(8'h10, 8'h20);
        wrap_up;
    end
    // Watchdog far beyond the roughly 120 cycles the sequence needs
    initial begin
        #100000;
        bad_count = bad_count + 1;
        wrap_up;
    end
endmodule
bind onoff_margin_ctrl onoff_margin_chk u_chk (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .cmd_wr_i(cmd_wr_i),
    .cmd_code_i(cmd_code_i),
    .cmd_raddr_i(cmd_raddr_i),
    .cmd_rdata_o(cmd_rdata_o),
    .cmd_wr_refused_o(cmd_wr_refused_o),
    .power_present_i(power_present_i),
    .out_enable_o(out_enable_o),
    .soft_off_o(soft_off_o),
    .fast_off_o(fast_off_o),
    .margin_sel_o(margin_sel_o),
    .margined_o(margined_o),
    .ovuv_ignore_o(ovuv_ignore_o)
);
